// >>> hw/rio_alloc_pkg.sv
// Package: constants, field layouts and carriers of the remote I/O image allocator
package rio_alloc_pkg;
  // ==========================================================
  // Image and parameter area placement
  localparam logic [15:0] IMG_BASE_WORD = 16'h07D0;
  localparam logic [15:0] IMG_UNIT_STRIDE = 16'h000A;
  localparam logic [15:0] PARAM_BASE_WORD = 16'h4E20;
  localparam logic [15:0] PARAM_UNIT_STRIDE = 16'h0064;
  localparam logic [15:0] PARAM_WORDS = 16'h0064;
  localparam logic [4:0] NARROW_OUT_WORDS = 5'h04;
  localparam logic [4:0] NARROW_STAT_WORDS = 5'h02;
  localparam logic [4:0] WIDE_OUT_WORDS = 5'h08;
  localparam logic [4:0] WIDE_STAT_WORDS = 5'h04;
  localparam logic [4:0] NARROW_LAST_NODE = 5'h07;
  localparam logic [4:0] WIDE_LAST_NODE = 5'h0F;
  // ==========================================================
  // APB byte addresses and control fields
  localparam logic [11:0] ADDR_CTRL = 12'h000;
  localparam logic [11:0] ADDR_IMG_FIRST = 12'h004;
  localparam logic [11:0] ADDR_PARAM_FIRST = 12'h008;
  localparam logic [11:0] ADDR_LAST_ALLOC = 12'h00C;
  localparam logic [11:0] ADDR_IMAGE = 12'h040;
  localparam logic [11:0] ADDR_IMAGE_END = 12'h090;
  localparam int CTRL_UNIT_LSB = 0;
  localparam int CTRL_UNIT_W = 7;
  localparam int CTRL_WIDE_BIT = 8;
  localparam int CTRL_RESTART_BIT = 31;
  localparam logic [6:0] UNIT_RESET = 7'h00;
  localparam logic WIDE_RESET = 1'b0;
  // ==========================================================
  // Bit masks inside one image word
  localparam logic [15:0] MASK_NIB_EVEN = 16'h000F;
  localparam logic [15:0] MASK_NIB_ODD = 16'h0F00;
  localparam logic [15:0] MASK_BYTE_EVEN = 16'h00FF;
  localparam logic [15:0] MASK_BYTE_ODD = 16'hFF00;
  localparam logic [15:0] MASK_WORD = 16'hFFFF;
  // ==========================================================
  // Carriers
  typedef enum logic [2:0] {
    KIND_P4 = 3'h0, KIND_P8 = 3'h1, KIND_P16 = 3'h2, KIND_P32 = 3'h3,
    KIND_A16 = 3'h4, KIND_A32 = 3'h5, KIND_A48 = 3'h6, KIND_A64 = 3'h7
  } kind_t;
  typedef enum logic [1:0] {
    DIR_OUT = 2'h0, DIR_IN = 2'h1, DIR_MIXED = 2'h2
  } dir_t;
  typedef struct packed {
    logic valid;
    dir_t dir;
    kind_t kind;
    logic [3:0] node;
  } join_req_t;
  typedef struct packed {
    logic valid;
    logic is_out;
    logic [3:0] node;
    logic error;
  } leave_req_t;
  typedef struct packed {
    logic ack;
    logic accepted;
    logic [15:0] word;
    logic [15:0] mask;
    logic [2:0] words;
  } alloc_t;
  typedef struct packed {
    logic valid;
    logic [2:0] idx;
    logic [15:0] data;
  } img_wr_t;
  typedef struct packed {
    logic psel;
    logic penable;
    logic pwrite;
    logic [11:0] paddr;
    logic [31:0] pwdata;
  } apb_req_t;
  typedef struct packed {
    logic pready;
    logic [31:0] prdata;
    logic pslverr;
  } apb_rsp_t;
endpackage

// >>> hw/remote_io_image_allocator.sv
// Remote I/O image allocator: maps slaves to image words, keeps node flags
//
// Register access over APB and the placing of the registers were decided locally.
`timescale 1ns/100ps
module remote_io_image_allocator (
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // APB register port
  input wire rio_alloc_pkg::apb_req_t apb_req,
  output rio_alloc_pkg::apb_rsp_t apb_rsp,
  // Slave join requests and allocation answers
  input wire rio_alloc_pkg::join_req_t join_req,
  output rio_alloc_pkg::alloc_t alloc,
  // Slave withdrawals
  input wire rio_alloc_pkg::leave_req_t leave_req,
  // Input image writes from the link side
  input wire rio_alloc_pkg::img_wr_t in_wr,
  // Output image read port for the link side
  input wire logic [2:0] out_rd_idx,
  output logic [15:0] out_rd_data,
  // Indicator
  output logic link_active_indicator
);
  import rio_alloc_pkg::*;

  typedef struct packed {
    logic wide;
    logic [6:0] unit;
    logic [15:0] act_out;
    logic [15:0] act_in;
    logic [15:0] err_out;
    logic [15:0] err_in;
    logic [7:0][15:0] out_img;
    logic [7:0][15:0] in_img;
    alloc_t alloc;
    logic [4:0] alloc_end;
    logic [15:0] out_rd;
    logic [31:0] prdata;
    logic pslverr;
    logic any_join;
  } state_t;

  state_t state_reg;
  state_t state_next;

  // ==========================================================
  // Derived placement
  logic [15:0] img_first;
  logic [15:0] param_first;
  logic [4:0] out_words;
  logic [4:0] stat_words;
  logic [4:0] last_node;
  logic [15:0] stat_word [4];

  assign img_first = 16'(IMG_BASE_WORD
                     + IMG_UNIT_STRIDE * {9'h000, state_reg.unit});
  assign param_first = 16'(PARAM_BASE_WORD
                       + PARAM_UNIT_STRIDE * {9'h000, state_reg.unit});
  assign out_words = state_reg.wide ? WIDE_OUT_WORDS
                                    : NARROW_OUT_WORDS;
  assign stat_words = state_reg.wide ? WIDE_STAT_WORDS
                                     : NARROW_STAT_WORDS;
  assign last_node = state_reg.wide ? WIDE_LAST_NODE
                                    : NARROW_LAST_NODE;

  // Status words follow the input words
  always_comb begin
    if (state_reg.wide) begin
      stat_word[0] = state_reg.act_out;
      stat_word[1] = state_reg.act_in;
      stat_word[2] = state_reg.err_out;
      stat_word[3] = state_reg.err_in;
    end else begin
      stat_word[0] = {state_reg.err_out[7:0], state_reg.act_out[7:0]};
      stat_word[1] = {state_reg.err_in[7:0], state_reg.act_in[7:0]};
      stat_word[2] = 16'h0000;
      stat_word[3] = 16'h0000;
    end
  end

  // ==========================================================
  // Allocation of one join request
  logic [3:0] node_cnt;
  logic [4:0] start_node;
  logic [4:0] end_node;
  logic fits;
  logic [15:0] first_mask;
  logic [4:0] rel_word;

  always_comb begin
    unique case (join_req.kind)
      KIND_P4, KIND_P8: node_cnt = 4'h1;
      KIND_P16, KIND_A16: node_cnt = 4'h2;
      KIND_P32, KIND_A32: node_cnt = 4'h4;
      KIND_A48: node_cnt = 4'h6;
      KIND_A64: node_cnt = 4'h8;
    endcase
    // Multi-node slaves start on the even node of the pair
    if (node_cnt == 4'h1) begin
      start_node = {1'b0, join_req.node};
    end else begin
      start_node = {1'b0, join_req.node[3:1], 1'b0};
    end
    end_node = 5'(start_node + {1'b0, node_cnt} - 5'h01);
    fits = (end_node <= last_node);
    unique case (join_req.kind)
      KIND_P4: first_mask = join_req.node[0] ? MASK_NIB_ODD
                                             : MASK_NIB_EVEN;
      KIND_P8: first_mask = join_req.node[0] ? MASK_BYTE_ODD
                                             : MASK_BYTE_EVEN;
      default: first_mask = MASK_WORD;
    endcase
    // Inputs sit after the output words; mixed reports the output word
    rel_word = {1'b0, start_node[4:1]};
    if (join_req.dir == DIR_IN) begin
      rel_word = 5'(rel_word + out_words);
    end
  end

  // ==========================================================
  // APB decode, reads sampled in the setup phase, writes taken in the access phase
  logic apb_setup;
  logic apb_wr;
  logic [4:0] img_rel;
  logic img_hit;
  logic [31:0] rd_data;
  logic rd_err;

  assign apb_setup = apb_req.psel && !apb_req.penable;
  assign apb_wr = apb_req.psel && apb_req.penable && apb_req.pwrite;
  assign img_rel = 5'((apb_req.paddr - ADDR_IMAGE) >> 2);
  assign img_hit = (apb_req.paddr >= ADDR_IMAGE)
                   && (apb_req.paddr < ADDR_IMAGE_END)
                   && (apb_req.paddr[1:0] == 2'h0);

  always_comb begin
    rd_data = 32'h0000_0000;
    rd_err = 1'b0;
    if (img_hit && img_rel < out_words) begin
      rd_data = {16'h0000, state_reg.out_img[img_rel[2:0]]};
    end else if (img_hit && img_rel < 5'(out_words << 1)) begin
      rd_data = {16'h0000, state_reg.in_img[3'(img_rel - out_words)]};
    end else if (img_hit
                 && img_rel < 5'((out_words << 1) + stat_words)) begin
      rd_data = {16'h0000,
                 stat_word[2'(img_rel - 5'(out_words << 1))]};
    end else if (apb_req.paddr == ADDR_CTRL) begin
      rd_data[CTRL_UNIT_LSB +: CTRL_UNIT_W] = state_reg.unit;
      rd_data[CTRL_WIDE_BIT] = state_reg.wide;
    end else if (apb_req.paddr == ADDR_IMG_FIRST) begin
      rd_data = {16'h0000, img_first};
    end else if (apb_req.paddr == ADDR_PARAM_FIRST) begin
      rd_data = {PARAM_WORDS, param_first};
    end else if (apb_req.paddr == ADDR_LAST_ALLOC) begin
      rd_data = {state_reg.alloc.accepted, state_reg.alloc.words,
                 12'h000, state_reg.alloc.mask};
    end else begin
      rd_err = 1'b1;
    end
  end

  // ==========================================================
  // Next state
  logic restart;
  assign restart = apb_wr && (apb_req.paddr == ADDR_CTRL)
                   && apb_req.pwdata[CTRL_RESTART_BIT];

  always_comb begin
    state_next = state_reg;
    state_next.alloc.ack = 1'b0;
    state_next.out_rd = state_reg.out_img[out_rd_idx];
    if (apb_setup) begin
      state_next.prdata = rd_data;
      state_next.pslverr = rd_err;
    end
    if (apb_wr && apb_req.paddr == ADDR_CTRL) begin
      state_next.unit = apb_req.pwdata[CTRL_UNIT_LSB +: CTRL_UNIT_W];
      state_next.wide = apb_req.pwdata[CTRL_WIDE_BIT];
    end
    if (apb_wr && img_hit && img_rel < out_words) begin
      state_next.out_img[img_rel[2:0]] = apb_req.pwdata[15:0];
    end
    if (in_wr.valid && {2'b00, in_wr.idx} < out_words) begin
      state_next.in_img[in_wr.idx] = in_wr.data;
    end
    // Restart first, so a same-cycle join or error still lands
    if (restart) begin
      state_next.act_out = 16'h0000;
      state_next.act_in = 16'h0000;
      state_next.err_out = 16'h0000;
      state_next.err_in = 16'h0000;
      state_next.any_join = 1'b0;
    end
    if (join_req.valid) begin
      state_next.alloc.ack = 1'b1;
      state_next.alloc.accepted = fits;
      state_next.alloc.word = 16'(img_first + {11'h000, rel_word});
      state_next.alloc.mask = first_mask;
      state_next.alloc.words = 3'((node_cnt + 4'h1) >> 1);
      state_next.alloc_end = end_node;
      if (fits) begin
        state_next.any_join = 1'b1;
        // Flags of both directions are indexed by the requested node, not the start node
        if (join_req.dir != DIR_IN) begin
          state_next.act_out[join_req.node] = 1'b1;
          state_next.err_out[join_req.node] = 1'b0;
        end
        if (join_req.dir != DIR_OUT) begin
          state_next.act_in[join_req.node] = 1'b1;
          state_next.err_in[join_req.node] = 1'b0;
        end
      end
    end
    // Withdrawal last, so an error report outranks a same-cycle join
    if (leave_req.valid && leave_req.is_out) begin
      state_next.err_out[leave_req.node] = leave_req.error;
    end
    if (leave_req.valid && !leave_req.is_out) begin
      state_next.err_in[leave_req.node] = leave_req.error;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_reg <= '0;
      state_reg.unit <= UNIT_RESET;
      state_reg.wide <= WIDE_RESET;
    end else begin
      state_reg <= state_next;
    end
  end

  // ==========================================================
  // Outputs
  assign apb_rsp.pready = 1'b1;
  assign apb_rsp.prdata = state_reg.prdata;
  assign apb_rsp.pslverr = state_reg.pslverr;
  assign alloc = state_reg.alloc;
  assign out_rd_data = state_reg.out_rd;
  // A refused slave never joins, so it cannot light the indicator
  assign link_active_indicator = state_reg.any_join;

  // ==========================================================
  // Checks
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  chk_image_first: assert property (
    img_first == 16'(16'h07D0 + 16'h000A * {9'h000, state_reg.unit}))
    else $error("first image word wrong");
  chk_param_first: assert property (
    param_first == 16'(16'h4E20 + 16'h0064 * {9'h000, state_reg.unit}))
    else $error("first parameter word wrong");
  chk_range_refuse: assert property (
    join_req.valid && ({1'b0, join_req.node} > last_node)
    |=> alloc.ack && !alloc.accepted)
    else $error("out of range slave was accepted");
  chk_active_sticky: assert property (
    state_reg.act_out[3] && !restart |=> state_reg.act_out[3])
    else $error("active flag dropped without restart");
  chk_restart_clear: assert property (
    restart && !join_req.valid && !leave_req.valid
    |=> state_reg.act_out == 16'h0000 && state_reg.act_in == 16'h0000
        && state_reg.err_out == 16'h0000 && state_reg.err_in == 16'h0000)
    else $error("flags not cleared by restart");
  chk_nibble_mask: assert property (
    join_req.valid && join_req.kind == KIND_P4
    |=> alloc.mask == ($past(join_req.node[0]) ? 16'h0F00 : 16'h000F))
    else $error("four point mask wrong");
  chk_mixed_both: assert property (
    join_req.valid && join_req.dir == DIR_MIXED && fits
    |=> state_reg.act_out[$past(join_req.node)]
        && state_reg.act_in[$past(join_req.node)])
    else $error("mixed slave not active in both regions");
  chk_pair_align: assert property (
    join_req.valid && join_req.kind == KIND_P16 && join_req.dir == DIR_OUT
    |=> alloc.word == 16'(img_first + {13'h0000, $past(join_req.node[3:1])})
        && alloc.words == 3'h1)
    else $error("sixteen point word misplaced");
  chk_node_limit: assert property (
    alloc.ack && alloc.accepted
    |-> state_reg.alloc_end <= (state_reg.wide ? 5'h0F : 5'h07))
    else $error("accepted slave exceeds node limit");
  chk_narrow_span: assert property (
    apb_setup && !state_reg.wide && apb_req.paddr == 12'h068
    |=> apb_rsp.pslverr)
    else $error("eleventh image word answered in narrow mode");
  chk_indicator_off: assert property (
    !link_active_indicator && join_req.valid && !fits
    |=> !link_active_indicator)
    else $error("refused slave lit the indicator");
  chk_leave_keeps: assert property (
    leave_req.valid && leave_req.is_out && !restart
    && state_reg.act_out[leave_req.node]
    |=> state_reg.act_out[$past(leave_req.node)])
    else $error("active flag dropped on withdrawal");
  chk_error_set: assert property (
    leave_req.valid && !leave_req.is_out && leave_req.error
    |=> state_reg.err_in[$past(leave_req.node)])
    else $error("input error flag not set on withdrawal");
  chk_input_offset: assert property (
    join_req.valid && join_req.dir == DIR_IN && join_req.kind == KIND_P8
    |=> alloc.word == 16'(img_first + {13'h0000, $past(join_req.node[3:1])}
                          + (state_reg.wide ? 16'h0008 : 16'h0004)))
    else $error("input slave word misplaced");
  chk_byte_mask: assert property (
    join_req.valid && join_req.kind == KIND_P8
    |=> alloc.mask == ($past(join_req.node[0]) ? 16'hFF00 : 16'h00FF))
    else $error("eight point mask wrong");
  chk_quad_span: assert property (
    join_req.valid && join_req.kind == KIND_P32
    |=> alloc.words == 3'h2 && alloc.mask == 16'hFFFF)
    else $error("thirty-two point span wrong");
  chk_analog_span: assert property (
    join_req.valid && join_req.kind == KIND_A48 |=> alloc.words == 3'h3)
    else $error("analog span wrong");
  chk_wide_span: assert property (
    apb_setup && state_reg.wide && apb_req.paddr == 12'h090
    |=> apb_rsp.pslverr)
    else $error("word past wide image answered");

  cov_wide_join: cover property (state_reg.wide && alloc.ack
                                 && alloc.accepted && alloc.words == 3'h4);
  cov_refused: cover property (alloc.ack && !alloc.accepted);
  cov_error_leave: cover property (leave_req.valid && leave_req.error
                                   ##1 state_reg.err_in != 16'h0000);
  cov_restart: cover property (state_reg.act_out != 16'h0000 && restart);
  cov_clean_leave: cover property (leave_req.valid && !leave_req.error);
endmodule

// >>> tb/host_cpu_model.sv
// Host controller model: APB master reaching the allocator registers
`timescale 1ns/100ps
module host_cpu_model (
  // Clock
  input wire logic pclk,
  // APB master side
  output rio_alloc_pkg::apb_req_t apb_req,
  input wire rio_alloc_pkg::apb_rsp_t apb_rsp
);
  import rio_alloc_pkg::*;
  initial apb_req = '0;
  // ==========================================================
  // One transfer; the request stands until pready is seen high
  task automatic xfer(input logic wr, input logic [11:0] a,
      input logic [31:0] wd, output logic [31:0] rd, output logic err);
    @(posedge pclk);
    apb_req <= '{psel: 1'b1, penable: 1'b0, pwrite: wr, paddr: a,
      pwdata: wd};
    @(posedge pclk);
    apb_req.penable <= 1'b1;
    @(posedge pclk);
    while (apb_rsp.pready !== 1'b1) begin
      @(posedge pclk);
    end
    rd = apb_rsp.prdata;
    err = apb_rsp.pslverr;
    // Released lines show garbage so stale values cannot pass
    apb_req <= '{psel: 1'b0, penable: 1'b0, pwrite: ~wr, paddr: ~a,
      pwdata: ~wd};
  endtask
endmodule

// >>> tb/test_remote_io_image_allocator.sv
// Self-checking bench of the remote I/O image allocator
`timescale 1ns/100ps
module test_remote_io_image_allocator;
  import rio_alloc_pkg::*;
  logic pclk;
  logic presetn;
  apb_req_t apb_req;
  apb_rsp_t apb_rsp;
  join_req_t join_req;
  alloc_t alloc;
  leave_req_t leave_req;
  img_wr_t in_wr;
  logic [2:0] out_rd_idx;
  logic [15:0] out_rd_data;
  logic link_active_indicator;
  int num_errors = 0;
  int tests_run = 0;
  int cycles = 0;
  logic [15:0] first;
  remote_io_image_allocator i_remote_io_image_allocator (.pclk(pclk),
    .presetn(presetn), .apb_req(apb_req), .apb_rsp(apb_rsp),
    .join_req(join_req), .alloc(alloc), .leave_req(leave_req),
    .in_wr(in_wr), .out_rd_idx(out_rd_idx), .out_rd_data(out_rd_data),
    .link_active_indicator(link_active_indicator));
  host_cpu_model i_host_cpu_model (.pclk(pclk), .apb_req(apb_req),
    .apb_rsp(apb_rsp));
  initial begin
    pclk = 1'b0;
    forever #50 pclk = ~pclk;
  end
  // ==========================================================
  // Report and hang guard
  task automatic end_of_test();
    $display("Checks %0d, mismatches %0d", tests_run, num_errors);
    if (num_errors == 0 && tests_run > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask
  always @(posedge pclk) begin
    cycles <= cycles + 1;
    if (cycles == 20000) begin
      num_errors = num_errors + 1;
      end_of_test();
    end
  end
  // ==========================================================
  // Access tasks
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    tests_run++;
    if (got !== exp) begin
      num_errors++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  function automatic logic [11:0] img(input int k);
    return ADDR_IMAGE + 12'(4 * k);
  endfunction
  task automatic rd(input logic [11:0] a, input logic [31:0] exp);
    logic [31:0] d;
    logic e;
    i_host_cpu_model.xfer(1'b0, a, 32'h0, d, e);
    chk({31'h0, e}, 32'h0);
    chk(d, exp);
  endtask
  task automatic rd_err(input logic [11:0] a);
    logic [31:0] d;
    logic e;
    i_host_cpu_model.xfer(1'b0, a, 32'h0, d, e);
    chk({31'h0, e}, 32'h1);
    chk(d, 32'h0);
  endtask
  task automatic wr(input logic [11:0] a, input logic [31:0] v);
    logic [31:0] d;
    logic e;
    i_host_cpu_model.xfer(1'b1, a, v, d, e);
  endtask
  // Ack comes exactly one cycle after the request edge
  task automatic jn(input dir_t dir, input kind_t kind,
      input logic [3:0] node, input logic ok, input logic [15:0] off,
      input logic [15:0] mask, input logic [2:0] words);
    @(posedge pclk);
    join_req <= '{valid: 1'b1, dir: dir, kind: kind, node: node};
    @(posedge pclk);
    join_req <= '{valid: 1'b0, dir: DIR_IN, kind: KIND_P8, node: ~node};
    #1;
    chk({31'h0, alloc.ack}, 32'h1);
    chk({31'h0, alloc.accepted}, {31'h0, ok});
    if (ok === 1'b1) begin
      chk({16'h0, alloc.word}, {16'h0, first + off});
      chk({16'h0, alloc.mask}, {16'h0, mask});
      chk({29'h0, alloc.words}, {29'h0, words});
    end
  endtask
  task automatic lv(input logic is_out, input logic [3:0] n, input logic e);
    @(posedge pclk);
    leave_req <= '{valid: 1'b1, is_out: is_out, node: n, error: e};
    @(posedge pclk);
    leave_req <= '{valid: 1'b0, is_out: ~is_out, node: ~n, error: ~e};
  endtask
  task automatic out_chk(input logic [2:0] k, input logic [15:0] exp);
    @(posedge pclk);
    out_rd_idx <= k;
    repeat (2) @(posedge pclk);
    #1;
    chk({16'h0, out_rd_data}, {16'h0, exp});
  endtask
  // ==========================================================
  // Main sequence
  initial begin
    presetn = 1'b0;
    join_req = '0;
    leave_req = '0;
    in_wr = '0;
    out_rd_idx = 3'h0;
    first = 16'h07D0;
    repeat (20) @(posedge pclk);
    presetn <= 1'b1;
    rd(ADDR_CTRL, 32'h0000_0000);
    rd(ADDR_IMG_FIRST, 32'h0000_07D0);
    rd(ADDR_PARAM_FIRST, 32'h0064_4E20);
    wr(ADDR_CTRL, 32'h0000_0005);
    first = 16'h0802;
    rd(ADDR_IMG_FIRST, 32'h0000_0802);
    rd(ADDR_PARAM_FIRST, 32'h0064_5014);
    rd(img(9), 32'h0000_0000);
    rd_err(img(10));
    // Refusals first, so the indicator must still be dark
    jn(DIR_IN, KIND_A32, 4'h6, 1'b0, 16'h0, 16'h0, 3'h0);
    jn(DIR_OUT, KIND_P8, 4'h8, 1'b0, 16'h0, 16'h0, 3'h0);
    chk({31'h0, link_active_indicator}, 32'h0);
    rd(img(8), 32'h0000_0000);
    jn(DIR_OUT, KIND_P8, 4'h3, 1'b1, 16'h1, 16'hFF00, 3'h1);
    jn(DIR_IN, KIND_P8, 4'h3, 1'b1, 16'h5, 16'hFF00, 3'h1);
    jn(DIR_OUT, KIND_P16, 4'h5, 1'b1, 16'h2, 16'hFFFF, 3'h1);
    jn(DIR_IN, KIND_P4, 4'h7, 1'b1, 16'h7, 16'h0F00, 3'h1);
    rd(ADDR_LAST_ALLOC, 32'h9000_0F00);
    jn(DIR_MIXED, KIND_P4, 4'h2, 1'b1, 16'h1, 16'h000F, 3'h1);
    jn(DIR_MIXED, KIND_P8, 4'h2, 1'b1, 16'h1, 16'h00FF, 3'h1);
    jn(DIR_OUT, KIND_P32, 4'h1, 1'b1, 16'h0, 16'hFFFF, 3'h2);
    jn(DIR_MIXED, KIND_P16, 4'h3, 1'b1, 16'h1, 16'hFFFF, 3'h1);
    jn(DIR_IN, KIND_A64, 4'h0, 1'b1, 16'h4, 16'hFFFF, 3'h4);
    jn(DIR_OUT, KIND_A48, 4'h3, 1'b1, 16'h1, 16'hFFFF, 3'h3);
    jn(DIR_OUT, KIND_A16, 4'h7, 1'b1, 16'h3, 16'hFFFF, 3'h1);
    jn(DIR_IN, KIND_A32, 4'h5, 1'b1, 16'h6, 16'hFFFF, 3'h2);
    chk({31'h0, link_active_indicator}, 32'h1);
    rd(img(8), 32'h0000_00AE);
    rd(img(9), 32'h0000_00AD);
    lv(1'b1, 4'h5, 1'b1);
    lv(1'b0, 4'h0, 1'b1);
    rd(img(8), 32'h0000_20AE);
    rd(img(9), 32'h0000_01AD);
    lv(1'b1, 4'h5, 1'b0);
    rd(img(8), 32'h0000_00AE);
    // Output words are host-written, input words link-written
    wr(img(3), 32'hFFFF_1234);
    rd(img(3), 32'h0000_1234);
    out_chk(3'h3, 16'h1234);
    @(posedge pclk);
    in_wr <= '{valid: 1'b1, idx: 3'h0, data: 16'hA5C3};
    @(posedge pclk);
    in_wr <= '{valid: 1'b0, idx: 3'h7, data: 16'h5A3C};
    wr(img(4), 32'h0000_5555);
    rd(img(4), 32'h0000_A5C3);
    wr(ADDR_CTRL, 32'h8000_0005);
    rd(ADDR_CTRL, 32'h0000_0005);
    rd(img(8), 32'h0000_0000);
    rd(img(9), 32'h0000_0000);
    chk({31'h0, link_active_indicator}, 32'h0);
    // Wide node range
    wr(ADDR_CTRL, 32'h0000_0105);
    rd(ADDR_CTRL, 32'h0000_0105);
    rd(img(19), 32'h0000_0000);
    rd_err(img(20));
    jn(DIR_OUT, KIND_A64, 4'h8, 1'b1, 16'h4, 16'hFFFF, 3'h4);
    jn(DIR_IN, KIND_P8, 4'hF, 1'b1, 16'hF, 16'hFF00, 3'h1);
    jn(DIR_IN, KIND_P32, 4'hE, 1'b0, 16'h0, 16'h0, 3'h0);
    rd(img(16), 32'h0000_0100);
    rd(img(17), 32'h0000_8000);
    wr(img(7), 32'h0000_00C3);
    out_chk(3'h7, 16'h00C3);
    // Second power-up with flags set: control, first status word and indicator must come back clear
    @(posedge pclk);
    presetn <= 1'b0;
    repeat (20) @(posedge pclk);
    presetn <= 1'b1;
    rd(ADDR_CTRL, 32'h0000_0000);
    rd(img(8), 32'h0000_0000);
    chk({31'h0, link_active_indicator}, 32'h0);
    end_of_test();
  end
endmodule
